/* rtl/smsp_pkg.sv */
package smsp_pkg;

  // ****************************************************************
  // Mode codes of the three-bit operating mode select field
  // ****************************************************************
  localparam logic [2:0] MODE_MST_DIV4  = 3'h0;
  localparam logic [2:0] MODE_MST_DIV16 = 3'h1;
  localparam logic [2:0] MODE_MST_DIV64 = 3'h2;
  localparam logic [2:0] MODE_MST_SUB   = 3'h3;
  localparam logic [2:0] MODE_MST_TMR   = 3'h4;
  localparam logic [2:0] MODE_SLAVE     = 3'h5;
  localparam logic [2:0] MODE_I2C       = 3'h6;
  localparam logic [2:0] MODE_NONE      = 3'h7;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [2:0] MODE_RST       = 3'h7;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam int         WORD_BITS      = 8;
  localparam logic [3:0] BIT_CNT_W      = 4'h8;
  // Half-period of the master clock, in system clocks, per mode
  localparam logic [5:0] HALF_DIV4      = 6'h02;
  localparam logic [5:0] HALF_DIV16     = 6'h08;
  localparam logic [5:0] HALF_DIV64     = 6'h20;

  // ****************************************************************
  // Configuration carried as one struct
  // ****************************************************************
  typedef struct packed {
    logic [2:0] mode;          // Operating mode select
    logic       enable;        // Module enable
    logic       sel_pin_en;    // Select pin enable
    logic       idle_pol;      // 1: clock idles low
    logic       edge_sel;      // Capture edge select, slave only; master samples at the trailing edge
    logic       msb_first;     // 1: MSB first
  } smsp_cfg_s;

  typedef enum logic [1:0] {
    SMSP_IDLE,
    SMSP_LEAD,
    SMSP_TRAIL
  } smsp_state_e;

endpackage

/* rtl/smsp_top.sv */
`timescale 1ns/1ns
`default_nettype none

module smsp_top
  import smsp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       CLK_EN_I,
  // Configuration
  input  wire smsp_cfg_s  CFG_I,
  input  wire logic       PIN_ROUTED_I,
  input  wire logic       SUB_TICK_I,
  input  wire logic       TMR_TICK_I,
  // Data register access
  input  wire logic       WR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       FLAG_CLR_I,
  output logic [7:0]      RDATA_O,
  output logic            DONE_O,
  output logic            INCOMPLETE_O,
  output logic            WCOL_O,
  output logic            BUSY_O,
  // Pins
  input  wire logic       SDI_I,
  output logic            SDO_O,
  output logic            SDO_OE_O,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE_O,
  input  wire logic       SLAVE_SELECT_N_I,
  output logic            SLAVE_SELECT_N_O,
  output logic            SLAVE_SELECT_N_OE_O,
  output logic            SDI_PULLUP_O
);

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  function automatic logic is_master(input logic [2:0] m);
    is_master = (m <= MODE_MST_TMR);
  endfunction

  logic active;
  logic master;
  logic slave;
  // Port live only when routed, enabled and in an SPI mode
  assign master = is_master(CFG_I.mode);
  assign slave  = (CFG_I.mode == MODE_SLAVE);
  assign active = CFG_I.enable & PIN_ROUTED_I & (master | slave);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sync1_q    <= 3'h7;
      sync2_q    <= 3'h7;
      // Matches the synchroniser's reset so no false edge follows reset
      sck_prev_q <= 1'h1;
    end else if (CLK_EN_I) begin
      sync1_q    <= {SLAVE_SELECT_N_I, SCK_I, SDI_I};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[1];
    end
  end

  logic sdi_s;
  logic sck_s;
  logic ss_n_s;
  assign sdi_s  = sync2_q[0];
  assign sck_s  = sync2_q[1];
  assign ss_n_s = sync2_q[2];

  // ****************************************************************
  // Edge handling
  // ****************************************************************
  // Idle level is the inverse of the polarity bit
  logic idle_lvl;
  logic cap_rise;
  assign idle_lvl = ~CFG_I.idle_pol;
  // Idle high: 0 rising, 1 falling; idle low: 0 falling, 1 rising
  assign cap_rise = CFG_I.edge_sel ^ ~CFG_I.idle_pol;

  // Slave selected when select pin unused, or when used and held low
  logic sl_sel;
  assign sl_sel = slave & (~CFG_I.sel_pin_en | ~ss_n_s);

  logic sl_rise;
  logic sl_fall;
  logic sl_cap;
  logic sl_shf;
  assign sl_rise = sck_s & ~sck_prev_q;
  assign sl_fall = ~sck_s & sck_prev_q;
  assign sl_cap  = cap_rise ? sl_rise : sl_fall;
  assign sl_shf  = cap_rise ? sl_fall : sl_rise;

  // ****************************************************************
  // Master clock generator
  // ****************************************************************
  logic [5:0] div_q;
  logic [5:0] half;
  logic       tick;
  always_comb begin
    unique case (CFG_I.mode)
      MODE_MST_DIV4:  half = HALF_DIV4;
      MODE_MST_DIV16: half = HALF_DIV16;
      default:        half = HALF_DIV64;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_q <= 6'h00;
    end else if (CLK_EN_I) begin
      if (div_q >= half - 6'h01) begin
        div_q <= 6'h00;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // Slow sources supply ready-made half-period ticks
  always_comb begin
    unique case (CFG_I.mode)
      MODE_MST_SUB: tick = SUB_TICK_I;
      MODE_MST_TMR: tick = TMR_TICK_I;
      default:      tick = (div_q == 6'h00);
    endcase
  end

  // ****************************************************************
  // Transfer engine
  // ****************************************************************
  smsp_state_e state_q;
  logic [7:0]  shreg_q;
  logic [3:0]  bits_q;
  logic        sck_q;
  logic        in_bit;
  logic        out_bit;
  logic        sl_busy;
  assign in_bit  = sdi_s;
  assign out_bit = CFG_I.msb_first ? shreg_q[7] : shreg_q[0];
  assign sl_busy = (bits_q != 4'h0) & (bits_q != BIT_CNT_W);

  function automatic logic [7:0] shift_in(input logic [7:0] r,
                                          input logic b,
                                          input logic msb);
    shift_in = msb ? {r[6:0], b} : {b, r[7:1]};
  endfunction

  logic done_set;
  logic inc_set;
  logic wcol_set;
  logic busy;
  assign busy = master ? (state_q != SMSP_IDLE) : sl_busy;
  // Write during a transfer is dropped and flagged
  assign wcol_set = WR_I & busy;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q  <= SMSP_IDLE;
      shreg_q  <= DATA_RST;
      bits_q   <= 4'h0;
      sck_q    <= 1'h1;
      done_set <= 1'h0;
      inc_set  <= 1'h0;
    end else if (CLK_EN_I) begin
      done_set <= 1'h0;
      inc_set  <= 1'h0;
      if (!active) begin
        state_q <= SMSP_IDLE;
        bits_q  <= 4'h0;
        sck_q   <= idle_lvl;
        if (WR_I) shreg_q <= WDATA_I;
      end else if (master) begin
        unique case (state_q)
          SMSP_IDLE: begin
            sck_q <= idle_lvl;
            if (WR_I) begin
              shreg_q <= WDATA_I;
              bits_q  <= 4'h0;
              state_q <= SMSP_LEAD;
            end
          end
          SMSP_LEAD: if (tick) begin
            sck_q   <= ~sck_q;
            state_q <= SMSP_TRAIL;
            // First clock edge away from idle
          end
          SMSP_TRAIL: if (tick) begin
            sck_q <= ~sck_q;
            if (bits_q == BIT_CNT_W - 4'h1) begin
              state_q  <= SMSP_IDLE;
              done_set <= 1'h1;
            end else begin
              state_q <= SMSP_LEAD;
            end
            bits_q <= bits_q + 4'h1;
          end
          default: state_q <= SMSP_IDLE;
        endcase
        // Sample just before the trailing edge: the two-flop input delay
        // leaves the far side's bit settled then, even at the fastest rate
        if (state_q == SMSP_TRAIL && tick) begin
          shreg_q <= shift_in(shreg_q, in_bit, CFG_I.msb_first);
        end
      end else begin
        // Slave: clock comes only from the far master
        if (!sl_sel) begin
          if (sl_busy && CFG_I.sel_pin_en) begin
            inc_set  <= 1'h1;
            done_set <= 1'h1;
          end
          bits_q <= 4'h0;
          if (WR_I) shreg_q <= WDATA_I;
        end else begin
          if (WR_I && !sl_busy) begin
            shreg_q <= WDATA_I;
            bits_q  <= 4'h0;
          end else if (sl_cap) begin
            shreg_q <= shift_in(shreg_q, in_bit, CFG_I.msb_first);
            if (bits_q == BIT_CNT_W - 4'h1) begin
              done_set <= 1'h1;
              bits_q   <= 4'h0;
            end else begin
              bits_q <= bits_q + 4'h1;
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Output bit holds stable across the capture edge
  // ****************************************************************
  logic sdo_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sdo_q <= 1'h0;
    end else if (CLK_EN_I) begin
      if (master && state_q == SMSP_IDLE && WR_I) begin
        // First bit must stand before the first clock edge leaves
        sdo_q <= CFG_I.msb_first ? WDATA_I[7] : WDATA_I[0];
      end else if (master || sl_shf || !sl_busy) begin
        sdo_q <= out_bit;
      end
    end
  end

  // ****************************************************************
  // Sticky flags, set wins over clear
  // ****************************************************************
  logic done_q;
  logic inc_q;
  logic wcol_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      done_q <= 1'h0;
      inc_q  <= 1'h0;
      wcol_q <= 1'h0;
    end else if (CLK_EN_I) begin
      done_q <= done_set | (done_q & ~FLAG_CLR_I);
      inc_q  <= inc_set  | (inc_q  & ~FLAG_CLR_I);
      wcol_q <= wcol_set | (wcol_q & ~FLAG_CLR_I);
    end
  end

  // ****************************************************************
  // Pin drive registers
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SDO_O               <= 1'h0;
      SDO_OE_O            <= 1'h0;
      SCK_O               <= 1'h1;
      SCK_OE_O            <= 1'h0;
      SLAVE_SELECT_N_O    <= 1'h1;
      SLAVE_SELECT_N_OE_O <= 1'h0;
      SDI_PULLUP_O        <= 1'h0;
      RDATA_O             <= DATA_RST;
      DONE_O              <= 1'h0;
      INCOMPLETE_O        <= 1'h0;
      WCOL_O              <= 1'h0;
      BUSY_O              <= 1'h0;
    end else if (CLK_EN_I) begin
      SDO_O               <= sdo_q;
      SDO_OE_O            <= active & (master | sl_sel);
      SCK_O               <= sck_q;
      SCK_OE_O            <= active & master;
      // Select drops with the starting write, so the far side's first
      // bit is through the synchronisers before it is sampled
      SLAVE_SELECT_N_O    <= ~((state_q != SMSP_IDLE) |
                               (active & master & WR_I));
      SLAVE_SELECT_N_OE_O <= active & master & CFG_I.sel_pin_en;
      SDI_PULLUP_O        <= active;
      RDATA_O             <= shreg_q;
      DONE_O              <= done_q;
      INCOMPLETE_O        <= inc_q;
      WCOL_O              <= wcol_q;
      BUSY_O              <= busy;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_NO_SCK_SLAVE: assert property (
    CLK_EN_I && !master |=> !SCK_OE_O)
    else $error("clock driven while not master");
  AST_IDLE_LEVEL: assert property (
    CLK_EN_I && state_q == SMSP_IDLE && master && active
      ##1 CLK_EN_I |=> SCK_O == ~$past(CFG_I.idle_pol, 2))
    else $error("clock idle level wrong");
  AST_SS_FLOAT: assert property (
    CLK_EN_I && !CFG_I.sel_pin_en |=> !SLAVE_SELECT_N_OE_O)
    else $error("select pin driven while disabled");
  AST_OFF_QUIET: assert property (
    CLK_EN_I && !CFG_I.enable |=> !SDO_OE_O && !SCK_OE_O)
    else $error("pins driven while disabled");
  AST_DONE_STICKY: assert property (
    CLK_EN_I && done_set |=> done_q)
    else $error("complete flag not set");
  AST_MODE_DECODE: assert property (
    slave |-> !master)
    else $error("mode decode overlap");
  AST_NOT_ROUTED: assert property (
    CLK_EN_I && !PIN_ROUTED_I |=> !SDO_OE_O)
    else $error("pins driven while not routed");
  AST_EIGHT_BITS: assert property (
    done_set && master |-> $past(bits_q) == BIT_CNT_W - 4'h1)
    else $error("transfer not eight bits");
  AST_PULLUP: assert property (
    CLK_EN_I && !active |=> !SDI_PULLUP_O)
    else $error("pull-high while inactive");

  COV_MASTER_DONE: cover property (master && done_set);
  COV_SLAVE_DONE: cover property (slave && done_set && !inc_set);
  COV_INCOMPLETE: cover property (inc_set);
  COV_WCOL: cover property (wcol_set);

endmodule

`default_nettype wire

/* bench/smsp_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module smsp_peer (
  // Pins seen from the far side
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       din_i,
  output logic            dout_o,
  output logic            sck_o,
  output logic            cs_n_o,
  // Frame setup
  input  wire logic       idle_low_i,
  input  wire logic       msb_i,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o
);
  logic [3:0] idx;
  logic       drv_q;

  // Bit position of shift step i
  function automatic int pos(input int i);
    return msb_i ? 7 - i : i;
  endfunction

  initial begin
    drv_q = 1'b0;
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    dout_o = 1'b0;
    idx = 4'h0;
    rx_o = 8'h00;
  end

  // Selected: first bit goes out before the first clock edge
  always @(negedge cs_n_i) begin
    if (!drv_q) begin
      idx = 4'h0;
      dout_o = tx_i[pos(0)];
    end
  end

  // Released line shows the inverse, never a stale level
  always @(posedge cs_n_i) begin
    if (!drv_q) begin
      dout_o = ~dout_o;
    end
  end

  // Slave role: sample on leading edge, shift on trailing edge
  always @(sck_i) begin
    if (!drv_q && cs_n_i === 1'b0) begin
      if (sck_i === idle_low_i) begin
        rx_o[pos(idx)] = din_i;
      end else if (idx < 4'h7) begin
        idx = idx + 4'h1;
        dout_o = tx_i[pos(idx)];
      end
    end
  end

  // Master role: only this side starts frames and drives the clock
  task automatic frame(input logic cap_lead, input int nbits);
    drv_q = 1'b1;
    sck_o = ~idle_low_i;
    #81 cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      if (cap_lead) dout_o = tx_i[pos(i)];
      #80 sck_o = ~sck_o;
      if (cap_lead) rx_o[pos(i)] = din_i;
      else dout_o = tx_i[pos(i)];
      #80 sck_o = ~sck_o;
      if (!cap_lead) rx_o[pos(i)] = din_i;
    end
    #80 cs_n_o = 1'b1;
    drv_q = 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/tb_smsp_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_smsp_top;
  import smsp_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic       clk, rst_n, wr, fclr, routed;
  logic [7:0] wdata, ptx, rdata, prx;
  logic [1:0] tcnt;
  smsp_cfg_s  cfg;
  logic       done, inc, wcol, busy, sdo, sdo_oe, sck, sck_oe;
  logic       ss, ss_oe, pu, p_sck, p_cs, p_dout;
  int         err_count, samples_checked, cycles;
  wire logic  sck_w = sck_oe ? sck : p_sck;
  wire logic  cs_w = ss_oe ? ss : p_cs;

  smsp_top smsp_top_i (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1), .CFG_I(cfg),
    .PIN_ROUTED_I(routed), .SUB_TICK_I(tcnt == 2'h0),
    .TMR_TICK_I(tcnt == 2'h2), .WR_I(wr), .WDATA_I(wdata),
    .FLAG_CLR_I(fclr), .RDATA_O(rdata), .DONE_O(done),
    .INCOMPLETE_O(inc), .WCOL_O(wcol), .BUSY_O(busy), .SDI_I(p_dout),
    .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SCK_I(sck_w), .SCK_O(sck),
    .SCK_OE_O(sck_oe), .SLAVE_SELECT_N_I(cs_w), .SLAVE_SELECT_N_O(ss),
    .SLAVE_SELECT_N_OE_O(ss_oe), .SDI_PULLUP_O(pu));

  smsp_peer smsp_peer_i (
    .sck_i(sck_w), .cs_n_i(cs_w), .din_i(sdo), .dout_o(p_dout),
    .sck_o(p_sck), .cs_n_o(p_cs), .idle_low_i(cfg.idle_pol),
    .msb_i(cfg.msb_first), .tx_i(ptx), .rx_o(prx));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Tick source for the slow master modes, a pulse every 4 clocks
  always @(posedge clk) tcnt <= tcnt + 2'h1;

  // Hang guard: well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic write(input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic clear();
    @(negedge clk);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("done", {7'h00, done}, 8'h01);
  endtask

  // One master transfer, far side answering with p
  task automatic xfer_m(input logic [2:0] md, input logic pol,
                        input logic msb, input logic [7:0] w,
                        input logic [7:0] p);
    cfg.mode = md;
    cfg.idle_pol = pol;
    cfg.msb_first = msb;
    ptx = p;
    clear();
    write(w);
    wait_done();
    repeat (4) @(negedge clk);
    chk("rx", rdata, p);
    chk("tx", prx, w);
    chk("pins", {4'h0, sck_oe, sck, ss_oe, pu}, {4'h0, 1'b1, ~pol, 2'h3});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    fclr = 1'b0;
    routed = 1'b1;
    wdata = 8'h00;
    ptx = 8'h00;
    tcnt = 2'h0;
    cycles = 0;
    err_count = 0;
    samples_checked = 0;
    cfg = '{MODE_NONE, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset", {rdata[3:0], sck_oe, sdo_oe, ss_oe, done}, 8'h00);
    $display("test reset done");
    // Off states: no function, I2C, disabled, pins not routed
    for (int k = 0; k < 4; k++) begin
      cfg.mode = (k == 0) ? MODE_NONE : (k == 1) ? MODE_I2C : MODE_MST_DIV4;
      cfg.enable = (k != 2);
      routed = (k != 3);
      clear();
      write(8'hA5);
      repeat (80) @(negedge clk);
      chk("off", {6'h00, sck_oe, sdo_oe}, 8'h00);
      if (k < 3) chk("off busy", {6'h00, busy, done}, 8'h00);
      if (k != 1) chk("off pullup", {7'h00, pu}, 8'h00);
    end
    $display("test off states done");
    routed = 1'b1;
    cfg.enable = 1'b1;
    // Every master mode, every polarity and bit order
    for (int m = 0; m < 5; m++) begin
      xfer_m(3'(m), m[0], m[1], 8'(8'hC1 ^ m), 8'(8'h2B ^ (m << 4)));
    end
    $display("test master modes done");
    // Second write during a transfer is refused
    cfg.mode = MODE_MST_DIV16;
    ptx = 8'h69;
    clear();
    write(8'h5A);
    repeat (6) @(negedge clk);
    write(8'hFF);
    chk("busy", {5'h00, busy, sdo_oe, ss}, 8'h06);
    wait_done();
    repeat (4) @(negedge clk);
    chk("wcol", {7'h00, wcol}, 8'h01);
    chk("wcol rx", rdata, 8'h69);
    chk("wcol tx", prx, 8'h5A);
    clear();
    chk("flags", {5'h00, done, wcol, inc}, 8'h00);
    cfg.sel_pin_en = 1'b0;
    repeat (4) @(negedge clk);
    chk("sel off", {7'h00, ss_oe}, 8'h00);
    cfg.sel_pin_en = 1'b1;
    $display("test collision done");
    // Slave frames for every polarity and capture edge
    cfg.mode = MODE_SLAVE;
    for (int s = 0; s < 4; s++) begin
      cfg.idle_pol = s[0];
      cfg.edge_sel = s[1];
      cfg.msb_first = s[0] ^ s[1];
      ptx = 8'(8'h9C ^ s);
      clear();
      write(8'(8'h36 << s));
      smsp_peer_i.frame(s[1], 8);
      repeat (8) @(negedge clk);
      chk("slave done", {6'h00, done, sck_oe}, 8'h02);
      chk("slave rx", rdata, 8'(8'h9C ^ s));
      chk("slave tx", prx, 8'(8'h36 << s));
    end
    $display("test slave done");
    // Select released after half a word
    clear();
    smsp_peer_i.frame(1'b1, 4);
    repeat (8) @(negedge clk);
    chk("incomplete", {6'h00, inc, done}, 8'h03);
    $display("test incomplete done");
    close_out();
  end
endmodule
`default_nettype wire
